//--- hdl/gpio_pin_config_port.sv
// Purpose: apb register front end of the gpio pin configuration port
// Assumes: single clock, synchronous active-high reset, pins synchronous
// Notes: zero-wait apb slave; unmapped addresses answer pslverr
module gpio_pin_config_port
	import gpio_cfg_pkg::*;
#(
	parameter int NP = NPINS
) (
	input  wire logic          CLOCK_I,
	input  wire logic          RESET_I,
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [11:0]   PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	input  wire logic [3:0]    PSTRB_I,
	output logic [31:0]        PRDATA_O,
	output logic               PREADY_O,
	output logic               PSLVERR_O,
	input  wire logic [NP-1:0] PIN_I,
	output logic [NP-1:0]      PIN_O,
	output logic [NP-1:0]      PIN_OE_O,
	output logic [NP-1:0]      PULL_UP_O,
	output logic [NP-1:0]      PULL_DOWN_O,
	input  wire logic [NP-1:0] HW_OUT_I,
	input  wire logic [NP-1:0] HW_OE_I,
	output logic [NP-1:0]      HW_IN_O,
	output logic [NP-1:0]      DMA_REQ_O,
	output logic               IRQ_O
);
	logic [2:0]    pin_sel_ff;
	logic [NP-1:0] out_ff;
	logic [NP-1:0] stat_ff;
	logic [NP-1:0] mask_ff;
	logic [31:0]   rdata_ff;
	logic [31:0]   nxt_rdata;
	logic [1:0]    dir_w  [NP];
	logic [2:0]    irq_w  [NP];
	logic [1:0]    drv_w  [NP];
	logic [2:0]    pad_w  [NP];
	logic [NP-1:0] dma_w;
	logic [NP-1:0] ev_w;
	logic [NP-1:0] in_w;
	logic [NP-1:0] sw_in_w;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	wire           acc      = PSEL_I & PENABLE_I;
	wire           wr       = acc & PWRITE_I & (PSTRB_I == 4'hF);
	wire [7:0]     sel      = PWDATA_I[SEL_LSB +: 8];
	wire           wr_dir   = wr & hit(PADDR_I, OFF_DIR_SET);
	wire           wr_irq   = wr & hit(PADDR_I, OFF_IRQ_SET);
	wire           wr_pad   = wr & hit(PADDR_I, OFF_PAD_SET);
	wire           wr_dmae  = wr & hit(PADDR_I, OFF_DMA_EN);
	wire           wr_dmad  = wr & hit(PADDR_I, OFF_DMA_DIS);
	wire           wr_psel  = wr & hit(PADDR_I, OFF_PIN_SEL);
	wire           wr_stat  = wr & hit(PADDR_I, OFF_IRQ_STAT);
	wire           wr_mask  = wr & hit(PADDR_I, OFF_IRQ_MASK);
	wire           wr_out   = wr & hit(PADDR_I, OFF_PIN_OUT);
	wire           mapped   = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= OFF_PIN_OUT);
	wire [NP-1:0]  clr_bits = wr_stat ? PWDATA_I[NP-1:0] : '0;

	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_pin
			gpio_pin_cell u_cell (
				.clk_i      (CLOCK_I),
				.rst_i      (RESET_I),
				.wr_dir_i   (wr_dir & sel[g]),
				.wr_irq_i   (wr_irq & sel[g]),
				.wr_pad_i   (wr_pad & sel[g]),
				.dma_set_i  (wr_dmae & sel[g]),
				.dma_clr_i  (wr_dmad & sel[g]),
				.dir_val_i  (PWDATA_I[VAL_LSB +: 2]),
				.irq_val_i  (PWDATA_I[VAL_LSB +: 3]),
				.drv_val_i  (PWDATA_I[DRV_LSB +: 2]),
				.pad_val_i  (PWDATA_I[PAD_LSB +: 3]),
				.pin_i      (PIN_I[g]),
				.out_val_i  (out_ff[g]),
				.hw_out_i   (HW_OUT_I[g]),
				.hw_oe_i    (HW_OE_I[g]),
				.dir_o      (dir_w[g]),
				.irq_type_o (irq_w[g]),
				.drv_o      (drv_w[g]),
				.pad_o      (pad_w[g]),
				.dma_en_o   (dma_w[g]),
				.event_o    (ev_w[g]),
				.dma_req_o  (DMA_REQ_O[g]),
				.pin_o      (PIN_O[g]),
				.pin_oe_o   (PIN_OE_O[g]),
				.pull_up_o  (PULL_UP_O[g]),
				.pull_down_o(PULL_DOWN_O[g]),
				.in_o       (in_w[g])
			);
			assign HW_IN_O[g] = (dir_w[g] == DIR_HW_CONTROL) & in_w[g];
			assign sw_in_w[g] = in_w[g];
		end
	endgenerate

	// one pin's direction, detect type, drive and pad type in one read word
	wire [31:0] cfg_word = {16'h0000,
	                        1'b0, pad_w[pin_sel_ff],
	                        2'h0, drv_w[pin_sel_ff],
	                        1'b0, irq_w[pin_sel_ff],
	                        2'h0, dir_w[pin_sel_ff]};

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
			unique case (PADDR_I)
				OFF_PIN_SEL:  nxt_rdata = {29'h0, pin_sel_ff};
				OFF_PIN_CFG:  nxt_rdata = cfg_word;
				OFF_DMA_STAT: nxt_rdata = {{(32-NP){1'b0}}, dma_w};
				OFF_IRQ_STAT: nxt_rdata = {{(32-NP){1'b0}}, stat_ff};
				OFF_IRQ_MASK: nxt_rdata = {{(32-NP){1'b0}}, mask_ff};
				OFF_PIN_IN:   nxt_rdata = {{(32-NP){1'b0}}, sw_in_w};
				OFF_PIN_OUT:  nxt_rdata = {{(32-NP){1'b0}}, out_ff};
				default:      nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			pin_sel_ff <= 3'h0;
			out_ff     <= '0;
			mask_ff    <= '0;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			if (wr_psel) pin_sel_ff <= PWDATA_I[2:0];
			if (wr_out) out_ff <= PWDATA_I[NP-1:0];
			if (wr_mask) mask_ff <= PWDATA_I[NP-1:0];
			rdata_ff <= nxt_rdata;
		end
	end

	// sticky status: a new event wins over a clear in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) stat_ff <= '0;
		else stat_ff <= (stat_ff & ~clr_bits) | ev_w;
	end

	assign PRDATA_O  = rdata_ff;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = acc & ~mapped;
	assign IRQ_O     = |(stat_ff & mask_ff);
endmodule

//--- pkg/gpio_cfg_pkg.sv
// Purpose: constants for the gpio pin configuration port
// Assumes: apb slave, 32-bit data, one word per register
// Notes: register offsets are byte addresses
// Operation
// - configuration writes carry an eight-bit select mask; only selected pins change
// - each pin holds direction: software input, software output or hardware control
// - direction of one chosen pin reads back in its programmed encoding
// - each pin selects falling, rising, both edges, low or high level detect
// - detect type of one chosen pin reads back in its programmed encoding
// - any pin can be enabled individually as a dma start trigger
// - any pin's dma trigger can be disabled without touching other pins
// - dma trigger enable never suppresses that pin's interrupt
// - each pin holds drive strength: 2 mA, 4 mA, 8 mA, 8 mA slew
// - input pins store pad settings; pull termination and the analog pad type (input reads 0) affect input
// - drive strength and pad type of one pin read back, inputs too
// - at most eight pins; single-pin operations name pins 0 to 7
// - after reset pins are gpio inputs, 2 mA, push-pull, no pull
package gpio_cfg_pkg;
	localparam int          NPINS        = 8;
	localparam logic [11:0] OFF_DIR_SET  = 12'h000;
	localparam logic [11:0] OFF_IRQ_SET  = 12'h004;
	localparam logic [11:0] OFF_PAD_SET  = 12'h008;
	localparam logic [11:0] OFF_DMA_EN   = 12'h00C;
	localparam logic [11:0] OFF_DMA_DIS  = 12'h010;
	localparam logic [11:0] OFF_PIN_SEL  = 12'h014;
	localparam logic [11:0] OFF_PIN_CFG  = 12'h018;
	localparam logic [11:0] OFF_DMA_STAT = 12'h01C;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h020;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h024;
	localparam logic [11:0] OFF_PIN_IN   = 12'h028;
	localparam logic [11:0] OFF_PIN_OUT  = 12'h02C;
	// write layout of set registers: mask in [7:0], value from bit 8
	localparam int          SEL_LSB      = 0;
	localparam int          VAL_LSB      = 8;
	localparam int          DRV_LSB      = 8;
	localparam int          PAD_LSB      = 12;
	// read layout of pin config word
	localparam int          RD_DIR_LSB   = 0;
	localparam int          RD_IRQ_LSB   = 4;
	localparam int          RD_DRV_LSB   = 8;
	localparam int          RD_PAD_LSB   = 12;
	localparam logic [1:0]  DIR_SW_IN    = 2'h0;
	localparam logic [1:0]  DIR_SW_OUT   = 2'h1;
	localparam logic [1:0]  DIR_HW_CONTROL = 2'h2;
	localparam logic [2:0]  IRQ_FALL     = 3'h0;
	localparam logic [2:0]  IRQ_RISE     = 3'h1;
	localparam logic [2:0]  IRQ_BOTH     = 3'h2;
	localparam logic [2:0]  IRQ_LOW      = 3'h3;
	localparam logic [2:0]  IRQ_HIGH     = 3'h4;
	localparam logic [1:0]  DRIVE_2MA    = 2'h0;
	localparam logic [1:0]  DRIVE_4MA    = 2'h1;
	localparam logic [1:0]  DRIVE_8MA    = 2'h2;
	localparam logic [1:0]  DRIVE_8MA_SLEW_CTL = 2'h3;
	localparam logic [2:0]  PAD_PUSH_PULL          = 3'h0;
	localparam logic [2:0]  PAD_PUSH_PULL_PULLUP   = 3'h1;
	localparam logic [2:0]  PAD_PUSH_PULL_PULLDOWN = 3'h2;
	localparam logic [2:0]  PAD_OPEN_DRAIN         = 3'h3;
	localparam logic [2:0]  PAD_OPEN_DRAIN_PULLUP  = 3'h4;
	localparam logic [2:0]  PAD_OPEN_DRAIN_PULLDOWN = 3'h5;
	localparam logic [2:0]  PAD_ANALOG   = 3'h6;
	localparam logic [1:0]  DIR_RST      = DIR_SW_IN;
	localparam logic [2:0]  IRQ_RST      = IRQ_FALL;
	localparam logic [1:0]  DRV_RST      = DRIVE_2MA;
	localparam logic [2:0]  PAD_RST      = PAD_PUSH_PULL;
endpackage

//--- hdl/gpio_pin_cell.sv
// Purpose: per-pin configuration store, event detect and pad control
// Assumes: pin input synchronous to clock
// Notes: one instance per pin
module gpio_pin_cell
	import gpio_cfg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       wr_dir_i,
	input  wire logic       wr_irq_i,
	input  wire logic       wr_pad_i,
	input  wire logic       dma_set_i,
	input  wire logic       dma_clr_i,
	input  wire logic [1:0] dir_val_i,
	input  wire logic [2:0] irq_val_i,
	input  wire logic [1:0] drv_val_i,
	input  wire logic [2:0] pad_val_i,
	input  wire logic       pin_i,
	input  wire logic       out_val_i,
	input  wire logic       hw_out_i,
	input  wire logic       hw_oe_i,
	output logic [1:0]      dir_o,
	output logic [2:0]      irq_type_o,
	output logic [1:0]      drv_o,
	output logic [2:0]      pad_o,
	output logic            dma_en_o,
	output logic            event_o,
	output logic            dma_req_o,
	output logic            pin_o,
	output logic            pin_oe_o,
	output logic            pull_up_o,
	output logic            pull_down_o,
	output logic            in_o
);
	logic [1:0] dir_ff;
	logic [2:0] irq_ff;
	logic [1:0] drv_ff;
	logic [2:0] pad_ff;
	logic       dma_ff;
	logic       prev_ff;
	logic       pin_o_ff;
	logic       pin_oe_ff;
	logic       ev_ff;
	wire        analog   = (pad_ff == PAD_ANALOG);
	wire        open_dr  = (pad_ff == PAD_OPEN_DRAIN) || (pad_ff == PAD_OPEN_DRAIN_PULLUP)
	                       || (pad_ff == PAD_OPEN_DRAIN_PULLDOWN);
	wire        in_bit   = analog ? 1'b0 : pin_i;
	wire        rise     = in_bit & ~prev_ff;
	wire        fall     = ~in_bit & prev_ff;
	wire        drv_val  = (dir_ff == DIR_HW_CONTROL) ? hw_out_i : out_val_i;
	wire        drv_en   = (dir_ff == DIR_HW_CONTROL) ? hw_oe_i : (dir_ff == DIR_SW_OUT);
	logic       nxt_ev;

	always_comb begin
		unique case (irq_ff)
			IRQ_FALL: nxt_ev = fall;
			IRQ_RISE: nxt_ev = rise;
			IRQ_BOTH: nxt_ev = rise | fall;
			IRQ_LOW:  nxt_ev = ~in_bit;
			IRQ_HIGH: nxt_ev = in_bit;
			default:  nxt_ev = 1'b0;
		endcase
	end

	// direction, detect type and dma enable each by their own strobe; drive and pad both by wr_pad_i
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_ff <= DIR_RST;
			irq_ff <= IRQ_RST;
			drv_ff <= DRV_RST;
			pad_ff <= PAD_RST;
			dma_ff <= 1'b0;
		end else begin
			if (wr_dir_i) dir_ff <= dir_val_i;
			if (wr_irq_i) irq_ff <= irq_val_i;
			if (wr_pad_i) drv_ff <= drv_val_i;
			if (wr_pad_i) pad_ff <= pad_val_i;
			if (dma_set_i) dma_ff <= 1'b1;
			else if (dma_clr_i) dma_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_ff   <= 1'b0;
			ev_ff     <= 1'b0;
			pin_o_ff  <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			prev_ff   <= in_bit;
			ev_ff     <= nxt_ev;
			// open drain drives low only
			pin_o_ff  <= open_dr ? 1'b0 : drv_val;
			pin_oe_ff <= ~analog & drv_en & (~open_dr | ~drv_val);
		end
	end

	assign dir_o       = dir_ff;
	assign irq_type_o  = irq_ff;
	assign drv_o       = drv_ff;
	assign pad_o       = pad_ff;
	assign dma_en_o    = dma_ff;
	assign event_o     = ev_ff;
	assign dma_req_o   = ev_ff & dma_ff;
	assign pin_o       = pin_o_ff;
	assign pin_oe_o    = pin_oe_ff;
	assign pull_up_o   = (pad_ff == PAD_PUSH_PULL_PULLUP) || (pad_ff == PAD_OPEN_DRAIN_PULLUP);
	assign pull_down_o = (pad_ff == PAD_PUSH_PULL_PULLDOWN)
	                     || (pad_ff == PAD_OPEN_DRAIN_PULLDOWN);
	assign in_o        = in_bit;
endmodule

//--- verification/gpio_port_chk.sv
// Purpose: port assertions for the gpio pin configuration port
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module
module gpio_port_chk
	import gpio_cfg_pkg::*;
#(
	parameter int NP = NPINS
) (
	input  wire logic          CLOCK_I,
	input  wire logic          RESET_I,
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [11:0]   PADDR_I,
	input  wire logic [31:0]   PRDATA_O,
	input  wire logic          PREADY_O,
	input  wire logic          PSLVERR_O,
	input  wire logic [NP-1:0] PIN_OE_O,
	input  wire logic [NP-1:0] PULL_UP_O,
	input  wire logic [NP-1:0] PULL_DOWN_O,
	input  wire logic [NP-1:0] HW_OE_I,
	input  wire logic [NP-1:0] HW_OUT_I,
	input  wire logic [NP-1:0] DMA_REQ_O,
	input  wire logic          IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	logic [1:0]    quiet_ff;
	logic [NP-1:0] hwoe_ff;
	logic [NP-1:0] hwout_ff;
	// cycles since the last write or peripheral drive change
	always_ff @(posedge CLOCK_I) begin
		hwoe_ff <= HW_OE_I;
		hwout_ff <= HW_OUT_I;
		if (RESET_I || (PSEL_I && PENABLE_I && PWRITE_I) || hwoe_ff != HW_OE_I
			|| hwout_ff != HW_OUT_I)
			quiet_ff <= 2'h0;
		else if (quiet_ff != 2'h3)
			quiet_ff <= quiet_ff + 2'h1;
	end
	sequence s_acc;
		PSEL_I && PENABLE_I;
	endsequence
	sequence s_bad;
		s_acc ##0 (PADDR_I > 12'h02C || PADDR_I[1:0] != 2'h0);
	endsequence
	chk_pready_high: assert property (PREADY_O)
		else $error("pready low");
	chk_err_unmapped: assert property (s_bad |-> PSLVERR_O)
		else $error("no error on unmapped address");
	chk_err_mapped: assert property (s_acc ##0 (PADDR_I <= 12'h02C && PADDR_I[1:0] == 2'h0)
		|-> !PSLVERR_O) else $error("error on mapped address");
	chk_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
		else $error("error outside access");
	chk_rdata_clear: assert property (s_acc |=> PRDATA_O == 32'h0)
		else $error("read data not cleared");
	chk_reset_idle: assert property ($fell(RESET_I) |-> !IRQ_O && PIN_OE_O == '0
		&& DMA_REQ_O == '0 && PULL_UP_O == '0 && PULL_DOWN_O == '0)
		else $error("outputs active after reset");
	chk_pull_excl: assert property ((PULL_UP_O & PULL_DOWN_O) == '0)
		else $error("pull-up and pull-down together");
	chk_oe_quiet: assert property (quiet_ff == 2'h3 |-> $stable(PIN_OE_O))
		else $error("pin enable moved without cause");
endmodule

bind gpio_pin_config_port gpio_port_chk #(.NP(NP)) i_chk (.CLOCK_I, .RESET_I, .PSEL_I,
	.PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .PIN_OE_O,
	.PULL_UP_O, .PULL_DOWN_O, .HW_OE_I, .HW_OUT_I, .DMA_REQ_O, .IRQ_O);

//--- verification/gpio_pad_model.sv
// Purpose: pads and board lines seen by the port
// Assumes: board drives a pin only where ext_en_i is set
// Notes: an undriven line without pull wanders
module gpio_pad_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pu_i,
	input  wire logic [7:0] pd_i,
	input  wire logic [7:0] ext_val_i,
	input  wire logic [7:0] ext_en_i,
	output logic [7:0]      lvl_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt_ff;
	always_ff @(posedge clk_i) flt_ff <= ~lvl_o;
	always_comb begin
		for (int n = 0; n < 8; n++)
			lvl_o[n] = oe_i[n] ? drv_i[n] : ext_en_i[n] ? ext_val_i[n] :
				pu_i[n] ? 1'b1 : pd_i[n] ? 1'b0 : flt_ff[n];
	end
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench for the gpio pin configuration port
// Assumes: apb master tasks, pad model on the pins
// Notes: pins 1 and 4 are later left to their pull-ups
module tb import gpio_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0]  pstrb = 4'hF;
	logic [7:0]  hw_out = 8'h00, hw_oe = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
	logic [7:0]  pin_in, pin_o, pin_oe, pu, pd, hw_in, dmaq;
	logic        pready, pslverr, irq, e;
	logic [31:0] exp_cfg [8];
	int          err_total = 0, total_checks = 0, cyc = 0;
	always #5 clk = ~clk;
	gpio_pin_config_port #(.NP(8)) i_dut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.PIN_I(pin_in), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .PULL_UP_O(pu), .PULL_DOWN_O(pd),
		.HW_OUT_I(hw_out), .HW_OE_I(hw_oe), .HW_IN_O(hw_in), .DMA_REQ_O(dmaq), .IRQ_O(irq));
	gpio_pad_model i_pads (.clk_i(clk), .drv_i(pin_o), .oe_i(pin_oe), .pu_i(pu), .pd_i(pd),
		.ext_val_i(ext_val), .ext_en_i(ext_en), .lvl_o(pin_in));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		xfer(1'b1, a, d, s);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0, 4'hF);
		chk(n, x, r);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int p = 0; p < 8; p++) begin
			wr(OFF_PIN_SEL, 32'(p));
			rdc("cfg reset", OFF_PIN_CFG, 32'h0);
		end
		chk("pulls reset", 32'h0, 32'({pu, pd}));
		$display("test reset_state done");
		for (int p = 0; p < 8; p++) begin
			exp_cfg[p] = 32'((p % 7) << 12 | (p % 4) << 8 | (p % 5) << 4 | (p % 3));
			wr(OFF_DIR_SET, 32'((p % 3) << 8 | 1 << p));
			wr(OFF_IRQ_SET, 32'((p % 5) << 8 | 1 << p));
			wr(OFF_PAD_SET, 32'((p % 7) << 12 | (p % 4) << 8 | 1 << p));
		end
		// partial strobe is ignored, then pins 1 and 4 become inputs
		wr(OFF_DIR_SET, 32'h0000_0101, 4'h3);
		wr(OFF_DIR_SET, 32'h0000_0012);
		exp_cfg[1][1:0] = 2'h0;
		exp_cfg[4][1:0] = 2'h0;
		for (int p = 0; p < 8; p++) begin
			wr(OFF_PIN_SEL, 32'(p));
			rdc("pin cfg", OFF_PIN_CFG, exp_cfg[p]);
		end
		chk("pull up", 32'h12, 32'(pu));
		chk("pull down", 32'h24, 32'(pd));
		ext_en <= 8'hED;
		xfer(1'b0, OFF_PIN_IN, 32'h0, 4'hF);
		chk("pulled inputs", 32'h12, r & 32'h12);
		hw_oe <= 8'h04;
		hw_out <= 8'h04;
		repeat (4) @(posedge clk);
		chk("hw control", 32'h7, {29'h0, pin_oe[2], pin_o[2], hw_in[2]});
		wr(OFF_PIN_OUT, 32'h0000_0080);
		repeat (2) @(posedge clk);
		chk("sw output", 32'h80, 32'(pin_o & pin_oe & 8'h80));
		$display("test config done");
		wr(OFF_IRQ_SET, 32'h0000_0401);
		wr(OFF_IRQ_STAT, 32'h0000_00FF);
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		wr(OFF_DMA_EN, 32'h0000_0081);
		wr(OFF_DMA_DIS, 32'h0000_0080);
		rdc("dma enables", OFF_DMA_STAT, 32'h1);
		chk("irq idle", 32'h0, 32'(irq));
		ext_val[0] <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irq with dma", 32'h1, 32'(irq));
		chk("dma request", 32'h1, 32'(dmaq));
		wr(OFF_DMA_DIS, 32'h0000_0001);
		@(posedge clk);
		chk("dma off", 32'h0, 32'(dmaq));
		xfer(1'b0, OFF_IRQ_STAT, 32'h0, 4'hF);
		chk("irq status", 32'h1, r & 32'h1);
		wr(OFF_IRQ_MASK, 32'h0);
		@(posedge clk);
		chk("irq masked", 32'h0, 32'(irq));
		ext_val[0] <= 1'b0;
		wr(OFF_IRQ_STAT, 32'h0000_0001);
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		chk("irq cleared", 32'h0, 32'(irq));
		// edge detect types: one event per edge, none while the level holds
		wr(OFF_IRQ_SET, 32'h0000_0101);
		wr(OFF_IRQ_STAT, 32'h0000_0001);
		ext_val[0] <= 1'b1;
		repeat (4) @(posedge clk);
		chk("rise event", 32'h1, 32'(irq));
		wr(OFF_IRQ_STAT, 32'h0000_0001);
		@(posedge clk);
		chk("edge not level", 32'h0, 32'(irq));
		wr(OFF_IRQ_SET, 32'h0000_0001);
		ext_val[0] <= 1'b0;
		repeat (4) @(posedge clk);
		chk("fall event", 32'h1, 32'(irq));
		$display("test irq_dma done");
		xfer(1'b0, 12'h030, 32'h0, 4'hF);
		chk("unmapped error", 32'h1, 32'(e));
		wr(12'h002, 32'h0000_01FF);
		chk("unaligned error", 32'h1, 32'(e));
		$display("test errors done");
		report_and_stop();
	end
endmodule
